// *** design/ioe_encoder.sv ***
// Inclinometer output encoder: sampling, unit selection, datagram bytes, AHB-Lite registers
//
// Behaviour
// - Acceleration unit: 24-bit two's complement per axis, LSB 2^-22 g.
// - Each 24-bit value goes out as three bytes, MSB first.
// - Incremental velocity unit: 24-bit two's complement, LSB 2^-25 m/s per sample.
// - Average unit: mean of the first 255 samples (at most) since previous transmission, acceleration scaling.
// - Integrated velocity unit: running sum since reset, incremental velocity scaling.
// - Integrated velocity wraps silently within [-0.25, 0.25) without status error.
// - Temperature: 16-bit two's complement, MSB first, LSB 2^-8 degrees Celsius.
// - Unsigned 8-bit sample counter advances once per internal 2000/s sample.
// - Sample counter rolls over from 255 to 0 without any error flag.
// - Latency is sent as an unsigned word.
// - Latency: 16-bit microsecond count, one microsecond per LSB, MSB first.
module ioe_encoder
  import ioe_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC_P = ioe_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Compensated sensor data and latency, same clock
  input wire ioe_pkg::ioe_samp_t samp_i,
  input wire logic [ioe_pkg::LAT_W-1:0] latency_i,
  // Datagram byte stream
  input wire logic byte_ready_i,
  output logic byte_valid_o,
  output ioe_pkg::ioe_byte_t byte_o
);

  import ioe_pkg::*;

  localparam int unsigned TW = $clog2(SAMPLE_CYC_P);

  if (SAMPLE_CYC_P < 2) begin : g_chk
    $error("ioe_encoder: SAMPLE_CYC_P must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    ioe_unit_t unit;
    logic cont;
    logic drop;
    logic [TW-1:0] timer;
    logic [CNT_W-1:0] cnt;
    logic [0:AXES-1][SUM_W-1:0] sum;
    logic [CNT_W-1:0] nsamp;
    logic [0:AXES-1][INCL_W-1:0] ivel;
    ioe_frame_t snap;
    ioe_ser_t ser;
    logic [4:0] idx;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic hready;
    logic hresp;
  } ioe_st_t;

  ioe_st_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Sign extension of one axis value into the accumulator width
  function automatic logic [SUM_W-1:0] sext24(input logic [INCL_W-1:0] v);
    sext24 = {{(SUM_W-INCL_W){v[INCL_W-1]}}, v};
  endfunction : sext24

  // Signed mean; truncates toward zero, which keeps the result within one sample's range
  function automatic logic [INCL_W-1:0] avg_div(input logic [SUM_W-1:0] s, input logic [CNT_W-1:0] k);
    logic signed [SUM_W-1:0] quo;
    quo = $signed(s) / $signed({1'b0, k});
    avg_div = quo[INCL_W-1:0];
  endfunction : avg_div

  // Byte idx of the frame, first field's top byte at index 0
  function automatic logic [7:0] frame_byte(input ioe_frame_t f, input logic [4:0] idx);
    logic [$bits(ioe_frame_t)-1:0] v;
    v = f;
    frame_byte = v[$bits(ioe_frame_t)-1-8*idx -: 8];
  endfunction : frame_byte

  ////////////////////////////////////////////////////////////////////////////
  // FIFO between serializer and byte port

  logic fifo_in_ready;
  logic fifo_in_valid;
  ioe_byte_t fifo_in;
  logic [LVL_W-1:0] fifo_level;
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out;

  ioe_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(fifo_in),
    .in_ready_o(fifo_in_ready),
    .out_ready_i(byte_ready_i),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out),
    .level_o(fifo_level)
  );

  assign fifo_in_valid = (q.ser == IOE_SEND);
  assign fifo_in.data = frame_byte(q.snap, q.idx);
  assign fifo_in.last = (q.idx == 5'(FRAME_BYTES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic tick;
  logic tx_req;
  logic [0:AXES-1][SUM_W-1:0] sum_now;
  logic [CNT_W-1:0] n_now;
  logic [31:0] rd_word;

  always_comb begin
    d = q;
    tx_req = 1'b0;
    rd_word = 32'h0000_0000;

    // Internal sample clock, 2000 samples per second
    tick = (q.timer == TW'(SAMPLE_CYC_P - 1));
    d.timer = tick ? '0 : q.timer + 1'b1;

    // Data phase of a write taken in the previous cycle
    d.wr_pend = 1'b0;
    if (q.wr_pend) begin
      case (q.wr_addr)
        ADDR_CTRL: begin
          d.unit = ioe_unit_t'(hwdata_i[CTRL_UNIT_LSB +: 2]);
          d.cont = hwdata_i[CTRL_CONT_BIT];
        end
        ADDR_CMD: begin
          tx_req = hwdata_i[CMD_TX_BIT];
          if (hwdata_i[CMD_DROP_CLR_BIT]) begin
            d.drop = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Register read word, built from current state
    case (haddr_i[11:0])
      ADDR_CTRL: begin
        rd_word[CTRL_UNIT_LSB +: 2] = q.unit;
        rd_word[CTRL_CONT_BIT] = q.cont;
      end
      ADDR_STATUS: begin
        rd_word[STAT_CNT_LSB +: CNT_W] = q.cnt;
        rd_word[STAT_BUSY_BIT] = (q.ser == IOE_SEND);
        rd_word[STAT_DROP_BIT] = q.drop;
        rd_word[STAT_LVL_LSB +: LVL_W] = fifo_level;
      end
      ADDR_LAT: begin
        rd_word[LAT_W-1:0] = q.snap.lat;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase

    // Address phase: zero wait states, response always OKAY
    d.hready = 1'b1;
    d.hresp = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      if (hwrite_i) begin
        d.wr_pend = 1'b1;
        d.wr_addr = {haddr_i[11:2], 2'b00};
      end else begin
        d.rdata = rd_word;
      end
    end

    // Per-sample work
    sum_now = q.sum;
    n_now = q.nsamp;
    if (tick) begin
      d.cnt = q.cnt + 1'b1;
      for (int a = 0; a < AXES; a++) begin
        d.ivel[a] = q.ivel[a] + samp_i.dvel[a];
        sum_now[a] = q.sum[a] + sext24(samp_i.acc[a]);
      end
      // Beyond 255 samples the mean stops taking new ones
      if (q.nsamp != 8'hFF) begin
        n_now = q.nsamp + 1'b1;
      end else begin
        sum_now = q.sum;
      end
      if (q.cont) begin
        tx_req = 1'b1;
      end
    end
    d.sum = sum_now;
    d.nsamp = n_now;

    // Serializer: one byte per cycle while the FIFO has room
    case (q.ser)
      IOE_IDLE: begin
        d.idx = '0;
      end
      IOE_SEND: begin
        if (fifo_in_ready) begin
          if (q.idx == 5'(FRAME_BYTES - 1)) begin
            d.ser = IOE_IDLE;
            d.idx = '0;
          end else begin
            d.idx = q.idx + 1'b1;
          end
        end
      end
      default: begin
        d.ser = IOE_IDLE;
      end
    endcase

    // Transmission: snapshot taken at the request, then bytes drain
    if (tx_req) begin
      if (q.ser == IOE_IDLE) begin
        for (int a = 0; a < AXES; a++) begin
          case (q.unit)
            IOE_UNIT_ACC: d.snap.incl[a] = samp_i.acc[a];
            IOE_UNIT_DVEL: d.snap.incl[a] = samp_i.dvel[a];
            IOE_UNIT_AVG: d.snap.incl[a] = (n_now == '0) ? samp_i.acc[a] : avg_div(sum_now[a], n_now);
            IOE_UNIT_IVEL: d.snap.incl[a] = d.ivel[a];
            default: d.snap.incl[a] = samp_i.acc[a];
          endcase
          d.snap.temp[a] = samp_i.temp[a];
        end
        d.snap.cnt = d.cnt;
        d.snap.lat = latency_i;
        d.sum = '0;
        d.nsamp = '0;
        d.ser = IOE_SEND;
        d.idx = '0;
      end else begin
        // Set after the clear so a coincident miss is kept
        d.drop = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.unit <= ioe_unit_t'(UNIT_RST);
      q.cont <= CONT_RST;
      q.ser <= IOE_IDLE;
      q.hready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign hrdata_o = q.rdata;
  assign hreadyout_o = q.hready;
  assign hresp_o = q.hresp;
  assign byte_valid_o = fifo_out_valid;
  assign byte_o = fifo_out;

  logic unused_ok;
  assign unused_ok = ^{haddr_i[31:12], haddr_i[1:0], hsize_i, htrans_i[0]};

endmodule : ioe_encoder

// *** design/ioe_pkg.sv ***
// Shared constants and types of the inclinometer output encoder
package ioe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SAMPLE_RATE_HZ = 2000;
  localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000_000 / SAMPLE_RATE_HZ;
  localparam int unsigned SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths and datagram shape
  localparam int unsigned AXES = 3;
  localparam int unsigned INCL_W = 24;
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned LAT_W = 16;
  localparam int unsigned SUM_W = 32;
  localparam int unsigned FRAME_BYTES = 18;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_W = 9;
  localparam int unsigned LVL_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_LAT = 12'h00C;

  // Field positions
  localparam int unsigned CTRL_UNIT_LSB = 0;
  localparam int unsigned CTRL_CONT_BIT = 2;
  localparam int unsigned CMD_TX_BIT = 0;
  localparam int unsigned CMD_DROP_CLR_BIT = 1;
  localparam int unsigned STAT_CNT_LSB = 0;
  localparam int unsigned STAT_BUSY_BIT = 8;
  localparam int unsigned STAT_DROP_BIT = 9;
  localparam int unsigned STAT_LVL_LSB = 12;

  // Reset values
  localparam logic [1:0] UNIT_RST = 2'h0;
  localparam logic CONT_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    IOE_UNIT_ACC = 2'b00,
    IOE_UNIT_DVEL = 2'b01,
    IOE_UNIT_AVG = 2'b10,
    IOE_UNIT_IVEL = 2'b11
  } ioe_unit_t;

  typedef enum logic [0:0] {
    IOE_IDLE = 1'b0,
    IOE_SEND = 1'b1
  } ioe_ser_t;

  typedef struct packed {
    logic [0:AXES-1][INCL_W-1:0] acc;
    logic [0:AXES-1][INCL_W-1:0] dvel;
    logic [0:AXES-1][TEMP_W-1:0] temp;
  } ioe_samp_t;

  typedef struct packed {
    logic [0:AXES-1][INCL_W-1:0] incl;
    logic [0:AXES-1][TEMP_W-1:0] temp;
    logic [CNT_W-1:0] cnt;
    logic [LAT_W-1:0] lat;
  } ioe_frame_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } ioe_byte_t;

endpackage : ioe_pkg

// *** design/ioe_fifo.sv ***
// Byte FIFO with a registered output stage
module ioe_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  // Fill level of the ring, output stage excluded
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("ioe_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } ioe_fifo_st_t;

  ioe_fifo_st_t q, d;
  logic push, pop, load;

  always_comb begin
    d = q;
    push = in_valid_i && (q.cnt != (PW+1)'(DEPTH));
    load = (q.cnt != '0) && (!q.ov || out_ready_i);
    pop = load;
    if (push) begin
      d.mem[q.wptr] = in_data_i;
      d.wptr = q.wptr + 1'b1;
    end
    if (load) begin
      d.od = q.mem[q.rptr];
      d.ov = 1'b1;
      d.rptr = q.rptr + 1'b1;
    end else if (out_ready_i) begin
      d.ov = 1'b0;
    end
    case ({push, pop})
      2'b10: d.cnt = q.cnt + 1'b1;
      2'b01: d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Ready is honest: it drops as soon as the ring is full
  assign in_ready_o = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = q.ov;
  assign out_data_o = q.od;
  assign level_o = q.cnt;

endmodule : ioe_fifo

// *** dv/ioe_sink.sv ***
// Receiver model taking datagram bytes promptly, slowly or not at all
module ioe_sink
  import ioe_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pace control
  input wire logic stall_i,
  input wire logic slow_i,
  // Byte stream
  input wire logic byte_valid_i,
  input wire ioe_pkg::ioe_byte_t byte_i,
  output logic byte_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ioe_byte_t q[$];
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      byte_ready_o <= 1'b0;
    end else begin
      if (byte_valid_i && byte_ready_o) begin
        q.push_back(byte_i);
      end
      // Slow pace drops ready every other cycle
      byte_ready_o <= !stall_i && !(slow_i && byte_ready_o);
    end
  end
endmodule : ioe_sink

// *** dv/ioe_encoder_chk.sv ***
// Port assertions of the inclinometer output encoder
module ioe_encoder_chk
  import ioe_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC_P = ioe_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Byte stream
  input wire logic byte_ready_i,
  input wire logic byte_valid_o,
  input wire ioe_pkg::ioe_byte_t byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tmr_q;
  logic [7:0] cnt_q;
  logic [4:0] idx_q;
  logic [15:0] lat_q;
  logic lat_ok_q;
  wire take = byte_valid_o && byte_ready_i;
  wire rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  // Away from the tick so no same-cycle ambiguity
  wire mid = tmr_q > 16'd2 && tmr_q < SAMPLE_CYC_P - 3;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tmr_q <= '0;
      cnt_q <= '0;
      idx_q <= '0;
      lat_ok_q <= 1'b0;
    end else begin
      tmr_q <= (tmr_q == SAMPLE_CYC_P - 1) ? '0 : tmr_q + 16'd1;
      if (tmr_q == SAMPLE_CYC_P - 1) begin
        cnt_q <= cnt_q + 8'd1;
      end
      if (take) begin
        idx_q <= (idx_q == 5'd17) ? '0 : idx_q + 5'd1;
        if (idx_q == 5'd16) begin
          lat_q[15:8] <= byte_o.data;
        end
        if (idx_q == 5'd17) begin
          lat_q[7:0] <= byte_o.data;
          lat_ok_q <= 1'b1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  hold_byte_a: assert property (byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o))
    else $error("byte changed while stalled");
  last_end_a: assert property (take && idx_q == 5'd17 |-> byte_o.last)
    else $error("last flag missing on byte 17");
  last_mid_a: assert property (take && idx_q != 5'd17 |-> !byte_o.last)
    else $error("last flag too early");
  cnt_read_a: assert property (rd && haddr_i[11:0] == ADDR_STATUS && mid |=> hrdata_o[7:0] == cnt_q)
    else $error("sample counter wrong");
  cnt_wrap_a: assert property (rd && haddr_i[11:0] == ADDR_STATUS && mid && cnt_q == 8'h00 ##1 1'b1 |-> hrdata_o[7:0] == 8'h00)
    else $error("counter did not roll to zero");
  lat_reg_a: assert property (rd && haddr_i[11:0] == ADDR_LAT && lat_ok_q && idx_q == 5'd0 && !byte_valid_o |=> hrdata_o == {16'h0000, lat_q})
    else $error("latency register differs from sent latency");
  unmap_a: assert property (rd && haddr_i[11:0] == 12'h010 |=> hrdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  bus_ok_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus wait or error response");
  rst_quiet_a: assert property (disable iff (1'b0) !rst_n_i |=> !byte_valid_o)
    else $error("byte valid after reset");
endmodule : ioe_encoder_chk
bind ioe_encoder ioe_encoder_chk #(.SAMPLE_CYC_P(SAMPLE_CYC_P)) u_chk (.clk_i, .rst_n_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .byte_ready_i, .byte_valid_o, .byte_o);

// *** dv/tb_ioe_encoder.sv ***
// Self-checking bench of the inclinometer output encoder
module tb_ioe_encoder
  import ioe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  ioe_samp_t samp;
  logic [15:0] lat = 16'hF00D;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic bvalid;
  logic bready;
  ioe_byte_t bdata;
  logic [31:0] rd;
  int tmr = 0;
  int ticks = 0;
  int n = 0;
  longint sum [AXES];
  int n_mismatch = 0;
  int checked = 0;
  always #10 clk = ~clk;
  ioe_encoder #(.SAMPLE_CYC_P(P)) u_dut (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .samp_i(samp), .latency_i(lat),
    .byte_ready_i(bready), .byte_valid_o(bvalid), .byte_o(bdata));
  ioe_sink u_sink (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .slow_i(slow), .byte_valid_i(bvalid),
    .byte_i(bdata), .byte_ready_o(bready));
  ////////////////////////////////////////////////////////////////
  // Tick mirror with running mean, capped at 255 samples
  always @(posedge clk) begin
    if (!rst_n) begin
      tmr <= 0;
      ticks <= 0;
      n <= 0;
      sum <= '{default: 0};
    end else if (tmr == P - 1) begin
      tmr <= 0;
      ticks <= ticks + 1;
      if (n < 255) begin
        n <= n + 1;
        for (int i = 0; i < AXES; i++) sum[i] <= sum[i] + signed'(samp.acc[i]);
      end
    end else begin
      tmr <= tmr + 1;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic mid();
    do @(posedge clk); while (tmr != P / 2);
  endtask : mid
  // Snapshot away from a tick, then compare all 18 bytes
  task automatic send(input ioe_unit_t u, input logic hold);
    ioe_frame_t f;
    logic [143:0] b;
    int w;
    mid();
    bus(1'b1, ADDR_CTRL, {30'h0, u});
    stall <= hold;
    bus(1'b1, ADDR_CMD, 32'h1);
    for (int i = 0; i < AXES; i++) begin
      f.incl[i] = u == IOE_UNIT_ACC ? samp.acc[i] : u == IOE_UNIT_DVEL ? samp.dvel[i] :
        u == IOE_UNIT_IVEL ? 24'(samp.dvel[i] * ticks) : n == 0 ? samp.acc[i] : 24'(sum[i] / n);
      sum[i] = 0;
    end
    n = 0;
    f.temp = samp.temp;
    f.cnt = ticks[7:0];
    f.lat = lat;
    b = f;
    if (hold) begin
      // Second request while busy is refused and flagged
      bus(1'b1, ADDR_CMD, 32'h1);
      repeat (30) @(posedge clk);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("fifo level", 32'(rd[15:12]), 32'h8);
      chk("busy flag", 32'(rd[8]), 32'h1);
      chk("drop flag set", 32'(rd[9]), 32'h1);
      bus(1'b1, ADDR_CMD, 32'h2);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("drop flag cleared", 32'(rd[9]), 32'h0);
      stall <= 1'b0;
    end
    w = 0;
    while (u_sink.q.size() < 18 && w < 300) begin
      @(posedge clk);
      w++;
    end
    chk("datagram length", 32'(u_sink.q.size()), 32'd18);
    for (int k = 0; k < 18; k++) chk("datagram byte", {23'h0, u_sink.q[k]}, {23'h0, k == 17, b[143-8*k -: 8]});
    u_sink.q.delete();
  endtask : send
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////
  initial begin
    samp.acc = {24'h123456, 24'hFEDCBA, 24'h800001};
    samp.dvel = {24'h300001, 24'hF00000, 24'h000007};
    samp.temp = {16'h1A80, 16'hFF00, 16'h8001};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    bus(1'b0, 12'h010, 32'h0);
    chk("unmapped read", rd, 32'h0);
    send(IOE_UNIT_ACC, 1'b0);
    slow <= 1'b1;
    send(IOE_UNIT_DVEL, 1'b1);
    slow <= 1'b0;
    repeat (40) @(posedge clk);
    send(IOE_UNIT_IVEL, 1'b0);
    send(IOE_UNIT_AVG, 1'b0);
    samp.acc <= {24'hFFFFFD, 24'h000005, 24'h7FFFFF};
    repeat (45) @(posedge clk);
    send(IOE_UNIT_AVG, 1'b0);
    while (ticks < 256) @(posedge clk);
    mid();
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("sample counter", 32'(rd[7:0]), 32'(ticks[7:0]));
    chk("drop flag", 32'(rd[9]), 32'h0);
    // Continuous mode: one datagram per sample, four samples fall in the window
    mid();
    bus(1'b1, ADDR_CTRL, 32'h4);
    repeat (70) @(posedge clk);
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    chk("cont length", 32'(u_sink.q.size()), 32'd72);
    chk("cont counter step", 32'(8'(u_sink.q[33].data - u_sink.q[15].data)), 32'h1);
    u_sink.q.delete();
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("cont drop flag", 32'(rd[9]), 32'h0);
    lat <= 16'h8001;
    send(IOE_UNIT_IVEL, 1'b0);
    bus(1'b0, ADDR_LAT, 32'h0);
    chk("latency reg", rd, 32'h0000_8001);
    // Mid-run reset must restart the integrator, counter and control
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl after reset", rd, 32'h0);
    send(IOE_UNIT_IVEL, 1'b0);
    test_done();
  end
  initial begin
    repeat (10000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : tb_ioe_encoder
